// ==== hdl/khi_host_if.sv ====
`timescale 1ns/100ps
`include "khi_defs.svh"
// ****************************************
// host mailbox of the keyboard controller
// ****************************************
module khi_host_if
  import khi_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // host bus
  input wire logic [9:0] hst_addr_i,
  input wire logic hst_aen_i,
  input wire logic hst_cs_n_i,
  input wire logic hst_ior_n_i,
  input wire logic hst_iow_n_i,
  input wire logic [7:0] hst_data_i,
  output logic [7:0] hst_data_o,
  output logic hst_data_oe_n_o,
  output logic hst_wr_room_o,
  // configuration
  input wire logic cfg_cs_src_i,
  // core instruction strobes
  input wire logic [7:0] core_acc_i,
  input wire logic core_store_i,
  input wire logic core_load_i,
  input wire logic core_sts_move_i,
  input wire logic core_f0_clr_i,
  input wire logic core_f0_cpl_i,
  input wire logic core_en_flags_i,
  input wire logic core_en_dma_i,
  input wire logic core_ibf_int_en_i,
  input wire logic core_ibf_int_dis_i,
  input wire logic core_p2_wr_i,
  input wire logic [3:0] core_p2_data_i,
  // core results
  output logic [7:0] core_data_o,
  output logic core_ibf_irq_o,
  output logic [10:0] core_irq_addr_o,
  // port lines 24 to 27
  output logic out_full_pin_o,
  output logic in_full_pin_o,
  output logic dma_request_pin_o,
  output logic port_line27_o,
  input wire logic dma_ack_pin_n_i,
  output logic flags_mode_o,
  output logic dma_mode_o
);

  // ****************************************
  // declarations
  // ****************************************
  khi_bus_st_t bus_st_reg;  // host cycle state
  logic [7:0] obuf_reg;  // core to host data
  logic obf_reg;  // output-full flag
  logic [7:0] hold_reg;  // host to core data
  logic ibf_reg;  // input-full flag
  logic f0_reg;  // general soft flag
  logic f1_reg;  // command/data flag
  logic [3:0] spare_reg;  // spare status flags
  logic ibf_ien_reg;  // input-full interrupt enable
  logic [3:0] p2_latch_reg;  // latch of lines 24..27
  logic flags_mode_reg;  // lines 24/25 carry flags
  logic dma_mode_reg;  // lines 26/27 carry dma
  logic drq_reg;  // pending dma request
  logic rd_a2_reg;  // current read targets status
  logic [7:0] status_word;
  logic pin_sel;
  logic dec_sel;
  logic dack_sel;
  logic dev_sel;
  logic acc_a2;
  logic rd_req;
  logic wr_req;
  logic rd_start;
  logic rd_end;
  logic push_now;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [8:0] fifo_out_data;

  // ****************************************
  // select decode
  // ****************************************
  // unit-select pin qualifies the access
  assign pin_sel = !hst_cs_n_i;
  // own decode of the two ports, aen low means a cpu cycle
  assign dec_sel = !hst_aen_i && ((hst_addr_i == `KHI_ADDR_DATA)
                   || (hst_addr_i == `KHI_ADDR_CMD));
  // acknowledge selects the data buffer regardless of address
  assign dack_sel = dma_mode_reg && !dma_ack_pin_n_i;
  assign dev_sel = (cfg_cs_src_i ? dec_sel : pin_sel) || dack_sel;
  // dma cycles always move data, never status
  assign acc_a2 = hst_addr_i[2] && !dack_sel;
  assign rd_req = dev_sel && !hst_ior_n_i;
  assign wr_req = dev_sel && !hst_iow_n_i;
  assign rd_start = (bus_st_reg == KHI_IDLE) && rd_req;
  assign rd_end = (bus_st_reg == KHI_READ) && !rd_req;
  // a read strobe wins if both come together
  assign push_now = (bus_st_reg == KHI_IDLE) && !rd_req && wr_req;
  assign status_word = {spare_reg, f1_reg, f0_reg, ibf_reg, obf_reg};

  // ****************************************
  // host cycle tracker
  // ****************************************
  // one action per strobe, so a long strobe is not seen twice
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      bus_st_reg <= KHI_IDLE;
      rd_a2_reg <= 1'b0;
    end
    else
    begin
      case (bus_st_reg)
        KHI_IDLE:
        begin
          if (rd_req)
          begin
            bus_st_reg <= KHI_READ;
            rd_a2_reg <= acc_a2;
          end
          else if (wr_req)
            bus_st_reg <= KHI_WRITE;
        end
        KHI_READ:
        begin
          if (!rd_req)
            bus_st_reg <= KHI_IDLE;
        end
        KHI_WRITE:
        begin
          if (!wr_req)
            bus_st_reg <= KHI_IDLE;
        end
        default:
          bus_st_reg <= KHI_IDLE;
      endcase
    end
  end

  // ****************************************
  // host read data
  // ****************************************
  // data is frozen at strobe start so the host sees a stable byte
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      hst_data_o <= `KHI_BYTE_RST;
      hst_data_oe_n_o <= 1'b1;
    end
    else
    begin
      if (rd_start)
        hst_data_o <= acc_a2 ? status_word : obuf_reg;
      hst_data_oe_n_o <= !(rd_start || ((bus_st_reg == KHI_READ) && rd_req));
    end
  end

  // ****************************************
  // core to host buffer and output-full
  // ****************************************
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      obuf_reg <= `KHI_BYTE_RST;
    else if (core_store_i)
      obuf_reg <= core_acc_i;
  end

  // store wins over a read ending in the same cycle
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      obf_reg <= 1'b0;
    else if (core_store_i)
      obf_reg <= 1'b1;
    else if (rd_end && !rd_a2_reg)
      obf_reg <= 1'b0;
  end

  // ****************************************
  // host to core path
  // ****************************************
  // host writes land only in the fifo, never in status
  khi_fifo #(
    .WIDTH(`KHI_FIFO_WIDTH),
    .DEPTH(`KHI_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .in_valid_i(push_now),
    .in_ready_o(fifo_in_ready),
    .in_data_i({acc_a2, hst_data_i}),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data)
  );

  // the fifo drains only when the core has taken the last byte
  assign fifo_out_ready = !ibf_reg || core_load_i;

  // host warned of a full fifo; a write while full is dropped
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      hst_wr_room_o <= 1'b0;
    else
      hst_wr_room_o <= fifo_in_ready;
  end

  // holding register seen by the core, a new byte beats the clear
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      hold_reg <= `KHI_BYTE_RST;
      ibf_reg <= 1'b0;
      f1_reg <= 1'b0;
    end
    else if (fifo_out_valid && fifo_out_ready)
    begin
      hold_reg <= fifo_out_data[7:0];
      f1_reg <= fifo_out_data[8];
      ibf_reg <= 1'b1;
    end
    else if (core_load_i)
      ibf_reg <= 1'b0;
  end

  // load instruction result
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      core_data_o <= `KHI_BYTE_RST;
    else if (core_load_i)
      core_data_o <= hold_reg;
  end

  // ****************************************
  // core-owned status flags
  // ****************************************
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      f0_reg <= 1'b0;
    else if (core_f0_clr_i)
      f0_reg <= 1'b0;
    else if (core_f0_cpl_i)
      f0_reg <= !f0_reg;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      spare_reg <= 4'h0;
    else if (core_sts_move_i)
      spare_reg <= core_acc_i[7:4];
  end

  // ****************************************
  // input-full interrupt toward the core
  // ****************************************
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      ibf_ien_reg <= 1'b0;
    else if (core_ibf_int_en_i)
      ibf_ien_reg <= 1'b1;
    else if (core_ibf_int_dis_i)
      ibf_ien_reg <= 1'b0;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      core_ibf_irq_o <= 1'b0;
      core_irq_addr_o <= 11'h000;
    end
    else
    begin
      core_ibf_irq_o <= ibf_reg && ibf_ien_reg;
      core_irq_addr_o <= `KHI_IBF_VECTOR;
    end
  end

  // ****************************************
  // port lines 24 to 27
  // ****************************************
  // latch starts at ones like every quasi-bidirectional line
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      p2_latch_reg <= `KHI_PORT_RST;
    else if (core_p2_wr_i)
      p2_latch_reg <= core_p2_data_i;
  end

  // mode switches, one-way until the next reset
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      flags_mode_reg <= 1'b0;
      dma_mode_reg <= 1'b0;
    end
    else
    begin
      if (core_en_flags_i)
        flags_mode_reg <= 1'b1;
      if (core_en_dma_i)
        dma_mode_reg <= 1'b1;
    end
  end

  // acknowledge or re-enable clears, and both beat a new request
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      drq_reg <= 1'b0;
    else if (core_en_dma_i || dack_sel)
      drq_reg <= 1'b0;
    else if (dma_mode_reg && core_p2_wr_i && core_p2_data_i[2])
      drq_reg <= 1'b1;
  end

  // pin drivers, one flop behind the flags
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      out_full_pin_o <= 1'b1;
      in_full_pin_o <= 1'b1;
      dma_request_pin_o <= 1'b1;
      port_line27_o <= 1'b1;
      flags_mode_o <= 1'b0;
      dma_mode_o <= 1'b0;
    end
    else
    begin
      out_full_pin_o <= flags_mode_reg ? (obf_reg && p2_latch_reg[0]) : p2_latch_reg[0];
      in_full_pin_o <= flags_mode_reg ? (!ibf_reg && p2_latch_reg[1]) : p2_latch_reg[1];
      dma_request_pin_o <= dma_mode_reg ? drq_reg : p2_latch_reg[2];
      // in dma mode line 27 is an input, so its driver floats high
      port_line27_o <= dma_mode_reg ? 1'b1 : p2_latch_reg[3];
      flags_mode_o <= flags_mode_reg;
      dma_mode_o <= dma_mode_reg;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_data_rd_end;
    rd_end && !rd_a2_reg && !core_store_i;
  endsequence

  sequence s_stat_rd_start;
    rd_start && acc_a2;
  endsequence

  AST_OBF_SET: assert property (core_store_i |=> obf_reg && obuf_reg == $past(core_acc_i))
    else $error("output-full or byte not set by store");
  AST_OBF_CLR: assert property (s_data_rd_end |=> !obf_reg)
    else $error("output-full not cleared by host data read");
  AST_RD_STATUS: assert property (s_stat_rd_start |=> hst_data_o == $past(status_word) && !hst_data_oe_n_o)
    else $error("status read returned wrong byte");
  AST_RD_DATA: assert property (rd_start && !acc_a2 |=> hst_data_o == $past(obuf_reg))
    else $error("data read returned wrong byte");
  AST_NO_SEL: assert property (!dev_sel && bus_st_reg == KHI_IDLE |=> bus_st_reg == KHI_IDLE)
    else $error("access taken without select");
  AST_LOAD: assert property (core_load_i && !fifo_out_valid |=> !ibf_reg && core_data_o == $past(hold_reg))
    else $error("load did not return byte or clear input-full");
  AST_STS_MOVE: assert property (core_sts_move_i |=> status_word[7:4] == $past(core_acc_i[7:4]))
    else $error("status move did not load spare flags");
  AST_DRQ_SET: assert property (dma_mode_reg && core_p2_wr_i && core_p2_data_i[2] && !dack_sel && !core_en_dma_i
    |=> drq_reg ##1 dma_request_pin_o)
    else $error("dma request not raised");
  AST_DRQ_CLR: assert property (dack_sel || core_en_dma_i |=> !drq_reg)
    else $error("dma request not cleared");
  AST_PIN24: assert property (flags_mode_reg |=> out_full_pin_o == $past(obf_reg && p2_latch_reg[0]))
    else $error("line 24 does not follow output-full");
  AST_IRQ: assert property (ibf_reg && ibf_ien_reg |=> core_ibf_irq_o)
    else $error("input-full interrupt missing");
  AST_RESET: assert property (@(posedge ref_clk_i) disable iff (1'b0)
    rst_i |=> !obf_reg && !ibf_reg && !ibf_ien_reg && !dma_mode_reg)
    else $error("reset did not clear flags and modes");
endmodule : khi_host_if

// ==== hdl/khi_defs.svh ====
// Function
// - select from unit-select pin when source bit 0
// - source bit 1: decode ports 60h, 64h
// - host data read returns last core-stored byte
// - host writes load buffer, core load returns it
// - status is read-only to the host
// - output-full set by store, cleared by host data read
// - input-full set by host write, cleared by load
// - core clears or toggles general soft flag
// - command/data flag captures A2 on host writes
// - status-move loads bits 4-7 from accumulator
// - A2 selects data or status; unselected does nothing
// - line 24 shows output-full, masked by latch
// - line 25 shows inverted input-full, masked by latch
// - DMA enable makes lines 26/27 request/acknowledge
// - DMA mode: writing 1 raises request
// - acknowledge lets host move byte on D0-D7
// - request cleared by acknowledge or DMA re-enable
// - full input buffer, enabled: interrupt to 003h
// - input-full interrupt disabled after reset
`ifndef KHI_DEFS_SVH
`define KHI_DEFS_SVH

// ****************************************
// host decode addresses
// ****************************************
`define KHI_ADDR_DATA 10'h060
`define KHI_ADDR_CMD 10'h064

// ****************************************
// status bit positions
// ****************************************
`define KHI_ST_OBF 0
`define KHI_ST_IBF 1
`define KHI_ST_F0 2
`define KHI_ST_F1 3
`define KHI_ST_SPARE_LO 4

// ****************************************
// reset values and constants
// ****************************************
`define KHI_PORT_RST 4'hf
`define KHI_BYTE_RST 8'h00
`define KHI_IBF_VECTOR 11'h003
`define KHI_FIFO_DEPTH 16
`define KHI_FIFO_WIDTH 9

`endif

// ==== hdl/khi_pkg.sv ====
// ****************************************
// shared types
// ****************************************
package khi_pkg;
  // host access cycle state, one-hot
  typedef enum logic [2:0] {
    KHI_IDLE = 3'b001,
    KHI_READ = 3'b010,
    KHI_WRITE = 3'b100
  } khi_bus_st_t;
endpackage : khi_pkg

// ==== hdl/khi_fifo.sv ====
`timescale 1ns/100ps
// ****************************************
// small fifo with registered read data
// ****************************************
module khi_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];  // storage array
  logic [AW-1:0] wr_ptr_reg;  // write index
  logic [AW-1:0] rd_ptr_reg;  // read index
  logic [AW:0] count_reg;  // words held in the array
  logic push;
  logic pop;

  // pop into the output register whenever it is free or drained
  assign in_ready_o = (count_reg != DEPTH[AW:0]);
  assign push = in_valid_i && in_ready_o;
  assign pop = (count_reg != '0) && (!out_valid_o || out_ready_i);

  // array write
  always_ff @(posedge ref_clk_i)
  begin
    if (push)
    begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // pointers and count
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      count_reg <= count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  // registered read data and its valid
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end
    else if (pop)
    begin
      out_valid_o <= 1'b1;
      out_data_o <= mem_reg[rd_ptr_reg];
    end
    else if (out_ready_i)
    begin
      out_valid_o <= 1'b0;
    end
  end
endmodule : khi_fifo

// ==== bench/khi_host_model.sv ====
`timescale 1ns/100ps
// ****************************************
// host bus model: one i/o master
// ****************************************
module khi_host_model (
  // clock
  input wire logic ref_clk_i,
  // bus toward the mailbox
  output logic [9:0] hst_addr_o,
  output logic hst_aen_o,
  output logic hst_cs_n_o,
  output logic hst_ior_n_o,
  output logic hst_iow_n_o,
  output logic [7:0] hst_data_o,
  // answer from the mailbox
  input wire logic [7:0] hst_data_i,
  input wire logic hst_data_oe_n_i
);
  // bus idle at time zero
  initial
  begin
    hst_addr_o = 10'h000;
    hst_aen_o = 1'b0;
    hst_cs_n_o = 1'b1;
    hst_ior_n_o = 1'b1;
    hst_iow_n_o = 1'b1;
    hst_data_o = 8'h00;
  end

  // write: strobe over one edge, then a quiet cycle
  task wr(input logic [9:0] a, input logic cs_n, input logic [7:0] d);
    @(negedge ref_clk_i);
    hst_addr_o = a;
    hst_cs_n_o = cs_n;
    hst_data_o = d;
    hst_iow_n_o = 1'b0;
    @(negedge ref_clk_i);
    hst_iow_n_o = 1'b1;
    hst_cs_n_o = 1'b1;
    // released bus shows the inverse, never a stale copy
    hst_data_o = ~d;
    @(negedge ref_clk_i);
  endtask : wr

  // read: hold strobe until the data enable is seen, bounded
  task rd(input logic [9:0] a, input logic cs_n, output logic [7:0] d, output logic ok);
    int i;
    ok = 1'b0;
    d = 8'h00;
    @(negedge ref_clk_i);
    hst_addr_o = a;
    hst_cs_n_o = cs_n;
    hst_ior_n_o = 1'b0;
    // enable is taken as sampled at the edge, so the strobe stands through it
    for (i = 0; i < 4 && !ok; i++)
    begin
      @(posedge ref_clk_i);
      if (hst_data_oe_n_i === 1'b0)
      begin
        ok = 1'b1;
        d = hst_data_i;
      end
    end
    @(negedge ref_clk_i);
    hst_ior_n_o = 1'b1;
    hst_cs_n_o = 1'b1;
    // strobe stays high so the next access is a new one
    repeat (2) @(negedge ref_clk_i);
  endtask : rd

  // address enable level for the accesses that follow
  task set_aen(input logic v);
    hst_aen_o = v;
  endtask : set_aen
endmodule : khi_host_model

// ==== bench/khi_host_if_bench.sv ====
`timescale 1ns/100ps
// ****************************************
// self-checking bench of the host mailbox
// ****************************************
module khi_host_if_bench;
  localparam int ST = 0, LD = 1, SM = 2, FC = 3, FT = 4, EF = 5, ED = 6, IE = 7, ID = 8, PW = 9;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cfg = 1'b0;
  logic ack_n = 1'b1;
  logic [7:0] acc = 8'h00;
  logic [9:0] cp = 10'h000; // core strobes, one bit each
  logic [9:0] addr;
  logic aen, cs_n, ior_n, iow_n, oe_n, room, irq, pf, pi, pq, p27, fm, dm;
  logic [7:0] hd_w, hd_r, cdat;
  logic [10:0] iaddr;
  int mismatches = 0;
  int checks = 0;

  always #10 ref_clk_i = ~ref_clk_i;

  khi_host_if dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .hst_addr_i(addr), .hst_aen_i(aen),
    .hst_cs_n_i(cs_n), .hst_ior_n_i(ior_n), .hst_iow_n_i(iow_n), .hst_data_i(hd_w),
    .hst_data_o(hd_r), .hst_data_oe_n_o(oe_n), .hst_wr_room_o(room), .cfg_cs_src_i(cfg),
    .core_acc_i(acc), .core_store_i(cp[0]), .core_load_i(cp[1]), .core_sts_move_i(cp[2]),
    .core_f0_clr_i(cp[3]), .core_f0_cpl_i(cp[4]), .core_en_flags_i(cp[5]), .core_en_dma_i(cp[6]),
    .core_ibf_int_en_i(cp[7]), .core_ibf_int_dis_i(cp[8]), .core_p2_wr_i(cp[9]),
    .core_p2_data_i(acc[3:0]), .core_data_o(cdat), .core_ibf_irq_o(irq), .core_irq_addr_o(iaddr),
    .out_full_pin_o(pf), .in_full_pin_o(pi), .dma_request_pin_o(pq), .port_line27_o(p27),
    .dma_ack_pin_n_i(ack_n), .flags_mode_o(fm), .dma_mode_o(dm));

  khi_host_model host (.ref_clk_i(ref_clk_i), .hst_addr_o(addr), .hst_aen_o(aen), .hst_cs_n_o(cs_n),
    .hst_ior_n_o(ior_n), .hst_iow_n_o(iow_n), .hst_data_o(hd_w), .hst_data_i(hd_r),
    .hst_data_oe_n_i(oe_n));

  // ****************************************
  // helpers
  // ****************************************
  task finish_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test

  task chk(input logic [10:0] got, input logic [10:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one-cycle core strobe with accumulator value
  task op(input int b, input logic [7:0] a);
    @(negedge ref_clk_i);
    acc = a;
    cp[b] = 1'b1;
    @(negedge ref_clk_i);
    cp = 10'h000;
  endtask : op

  task idle(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask : idle

  task st(output logic [7:0] s);
    logic ok;
    host.rd(10'h064, 1'b0, s, ok);
  endtask : st

  // ****************************************
  // scenarios
  // ****************************************
  logic [7:0] s, d;
  logic ok;

  task t_reset;
    chk(iaddr, 11'h003);
    chk({pf, pi, pq, p27}, 4'hf);
    chk({fm, dm, irq}, 3'h0);
    st(s);
    chk(s, 8'h00);
  endtask : t_reset

  // unselected accesses must leave no trace
  task t_select;
    host.rd(10'h060, 1'b1, d, ok);
    chk(ok, 1'b0);
    host.wr(10'h060, 1'b1, 8'h11);
    idle(3);
    st(s);
    chk(s[1], 1'b0);
    cfg = 1'b1;
    host.rd(10'h068, 1'b0, d, ok);
    chk(ok, 1'b0);
    host.wr(10'h061, 1'b0, 8'h22);
    idle(3);
    host.rd(10'h064, 1'b1, s, ok);
    chk({ok, s[1]}, 2'b10);
    host.set_aen(1'b1);
    host.rd(10'h060, 1'b0, d, ok);
    chk(ok, 1'b0);
    host.set_aen(1'b0);
    cfg = 1'b0;
  endtask : t_select

  task t_store_read;
    op(ST, 8'ha5);
    idle(1);
    st(s);
    chk(s[0], 1'b1);
    host.rd(10'h060, 1'b0, d, ok);
    chk(d, 8'ha5);
    st(s);
    chk(s[0], 1'b0);
    op(ST, 8'h01);
    op(ST, 8'h02);
    host.rd(10'h060, 1'b0, d, ok);
    chk(d, 8'h02);
  endtask : t_store_read

  task t_write_load;
    host.wr(10'h060, 1'b0, 8'h3c);
    idle(3);
    st(s);
    chk({s[3], s[1]}, 2'b01);
    op(LD, 8'h00);
    idle(1);
    chk(cdat, 8'h3c);
    st(s);
    chk(s[1], 1'b0);
    host.wr(10'h064, 1'b0, 8'hc3);
    idle(3);
    st(s);
    chk({s[3], s[1]}, 2'b11);
    op(LD, 8'h00);
    idle(1);
    chk(cdat, 8'hc3);
  endtask : t_write_load

  task t_status;
    op(SM, 8'ha0);
    op(FT, 8'h00);
    st(s);
    chk({s[7:4], s[2]}, 5'b10101);
    op(FT, 8'h00);
    st(s);
    chk(s[2], 1'b0);
    op(FT, 8'h00);
    op(FC, 8'h00);
    st(s);
    chk(s[2], 1'b0);
    // a write at the status address is a command, not a status store
    host.wr(10'h064, 1'b0, 8'h0f);
    idle(3);
    st(s);
    chk(s[7:4], 4'ha);
    op(LD, 8'h00);
  endtask : t_status

  task t_irq;
    host.wr(10'h060, 1'b0, 8'h5a);
    idle(4);
    chk(irq, 1'b0);
    op(IE, 8'h00);
    idle(2);
    chk(irq, 1'b1);
    op(LD, 8'h00);
    idle(2);
    chk(irq, 1'b0);
    op(ID, 8'h00);
    host.wr(10'h060, 1'b0, 8'h5b);
    idle(4);
    chk(irq, 1'b0);
    op(LD, 8'h00);
  endtask : t_irq

  task t_flags;
    op(EF, 8'h00);
    op(ST, 8'h77);
    idle(3);
    chk({fm, pf, pi}, 3'b111);
    host.rd(10'h060, 1'b0, d, ok);
    chk(pf, 1'b0);
    host.wr(10'h060, 1'b0, 8'h44);
    idle(4);
    chk(pi, 1'b0);
    op(PW, 8'h0c);
    op(LD, 8'h00);
    op(ST, 8'h78);
    idle(3);
    chk({pf, pi}, 2'b00);
    op(PW, 8'h0f);
    idle(3);
    chk({pf, pi}, 2'b11);
    host.rd(10'h060, 1'b0, d, ok);
  endtask : t_flags

  task t_dma;
    op(ED, 8'h00);
    idle(2);
    chk({dm, p27, pq}, 3'b110);
    op(PW, 8'h0f);
    idle(2);
    chk(pq, 1'b1);
    op(ST, 8'h9e);
    ack_n = 1'b0;
    host.rd(10'h000, 1'b1, d, ok);
    ack_n = 1'b1;
    chk({ok, d}, {1'b1, 8'h9e});
    chk(pq, 1'b0);
    op(PW, 8'h0f);
    idle(2);
    chk(pq, 1'b1);
    op(ED, 8'h00);
    idle(2);
    chk(pq, 1'b0);
  endtask : t_dma

  // fill with the core stalled, then drain in order
  task t_fifo;
    int n;
    int i;
    n = 0;
    while (room === 1'b1 && n < 40)
    begin
      host.wr(10'h060, 1'b0, n[7:0]);
      idle(1);
      n++;
    end
    chk(room, 1'b0);
    host.wr(10'h060, 1'b0, 8'hee);
    for (i = 0; i < n; i++)
    begin
      op(LD, 8'h00);
      idle(1);
      chk(cdat, i[7:0]);
      idle(3);
    end
    st(s);
    chk(s[1], 1'b0);
  endtask : t_fifo

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial
  begin
    repeat (5) @(negedge ref_clk_i);
    rst_i = 1'b0;
    idle(1);
    t_reset;
    t_select;
    t_store_read;
    t_write_load;
    t_status;
    t_irq;
    t_flags;
    t_dma;
    t_fifo;
    finish_test;
  end

  // whole run needs well under this many cycles
  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    mismatches++;
    $display("[FAIL] %0t watchdog", $time);
    finish_test;
  end
endmodule : khi_host_if_bench
